// ===== design/awsc_defs.vh
`ifndef AWSC_DEFS_VH
`define AWSC_DEFS_VH
// Register indices; byte address is four times the index
`define AWSC_IDX_GEN_CTRL   5'h00
`define AWSC_IDX_ACC_CTRL   5'h01
`define AWSC_IDX_REF_CTRL   5'h02
`define AWSC_IDX_DLY_CTRL   5'h03
`define AWSC_IDX_WIN_CTRL   5'h04
`define AWSC_IDX_SAMP_CTRL  5'h05
`define AWSC_IDX_CHAN_SEL   5'h06
`define AWSC_IDX_CMD        5'h08
`define AWSC_IDX_EVT_CTRL   5'h09
`define AWSC_IDX_INT_EN     5'h0a
`define AWSC_IDX_INT_FLAG   5'h0b
`define AWSC_IDX_DBG_CTRL   5'h0c
`define AWSC_IDX_SCRATCH    5'h0d
`define AWSC_IDX_RESULT     5'h10
`define AWSC_IDX_LOW_THR    5'h12
`define AWSC_IDX_HIGH_THR   5'h14
`define AWSC_IDX_TRIM       5'h16
// Writable bit masks; reserved bits read zero
`define AWSC_MSK_GEN_CTRL   8'h87
`define AWSC_MSK_ACC_CTRL   8'h07
`define AWSC_MSK_REF_CTRL   8'h77
`define AWSC_MSK_WIN_CTRL   8'h07
`define AWSC_MSK_SAMP_CTRL  8'h1f
`define AWSC_MSK_CHAN_SEL   8'h1f
`define AWSC_MSK_BIT0       8'h01
`define AWSC_MSK_INT        8'h03
// Field positions
`define AWSC_B_ENABLE       0
`define AWSC_B_CONTINUOUS   1
`define AWSC_B_RES8         2
`define AWSC_B_STBY_RUN     7
`define AWSC_B_RDY          0
`define AWSC_B_WIN          1
// Window mode codes
`define AWSC_WM_OFF         3'h0
`define AWSC_WM_BELOW       3'h1
`define AWSC_WM_ABOVE       3'h2
`define AWSC_WM_INSIDE      3'h3
`define AWSC_WM_OUTSIDE     3'h4
// Accumulation and delay codes
`define AWSC_ACC_RSVD       3'h7
`define AWSC_DLY_NONE       3'h0
`define AWSC_DLY_MAX        3'h5
`define AWSC_DLY_BASE       9'h008
// Fixed part of one conversion in converter clocks
`define AWSC_CONV_BASE      9'h00d
// Reset value of all registers
`define AWSC_RST8           8'h00
`define AWSC_RST16          16'h0000
`endif

// ===== design/awsc_prescaler.v
`timescale 1ns/1ps
`default_nettype none
// Converter clock enable: one tick every 2^(code+1) system clocks
module awsc_prescaler #(
  parameter CNT_W = 8
) (
  input  wire             clk_sys,
  input  wire             sys_rst,
  input  wire             ce,
  input  wire [2:0]       div_code,
  output reg              tick_ff
);
  reg  [CNT_W-1:0] cnt_ff;      // Free running divider
  wire [CNT_W-1:0] nxt_cnt;     // Next divider value
  wire [CNT_W-1:0] lim;         // Terminal count

  assign nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
  assign lim = (({{(CNT_W-1){1'b0}}, 1'b1} << div_code) << 1) - {{(CNT_W-1){1'b0}}, 1'b1};

  // Count and emit one-cycle tick at terminal count
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_ff  <= {CNT_W{1'b0}};
      tick_ff <= 1'b0;
    end else if (ce) begin
      tick_ff <= (cnt_ff >= lim);
      cnt_ff  <= (cnt_ff >= lim) ? {CNT_W{1'b0}} : nxt_cnt;
    end
  end
endmodule // awsc_prescaler
`default_nettype wire

// ===== design/awsc_top.v
// Behaviour
// - Compare below, above, inside, outside thresholds
// - Thresholds come from the two threshold registers
// - Window modes 1 to 4 enable comparator
// - Compare only final accumulated result once
// - Event trigger starts conversion when enabled
// - Result event pulse is one clock
// - Flags set on result and window match
// - Interrupt while flag and enable set
// - Standby halts converter unless run enabled
// - Standby with run lets conversion finish
// - Standby requests clock only while start bit set or converting
// - Event edge sets start bit, completion clears unless continuous
// - Power-down pauses conversion, resumes after wake
// - Start bit and event enable bit registers
// - Conversion begins on next converter clock
// - Continuous mode restarts after each completion
// - Accumulate one to 64 results
// - Initialization delay 0 to 256 converter clocks
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "awsc_defs.vh"
module awsc_top #(
  parameter ADDR_W = 7,
  parameter DATA_W = 10
) (
  input  wire              clk_sys,
  input  wire              sys_rst,
  input  wire              ce,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata_ff,
  output reg               pready_ff,
  output reg               pslverr_ff,
  input  wire              event_trigger,
  input  wire [DATA_W-1:0] sample_data,
  input  wire              standby_sleep,
  input  wire              power_down_sleep,
  output reg               result_event_ff,
  output reg               irq_ff,
  output reg               clk_request_ff
);
  localparam ST_IDLE = 2'b00;  // Waiting for start
  localparam ST_INIT = 2'b01;  // Initialization delay
  localparam ST_CONV = 2'b10;  // Converting one sample
  // Register storage
  reg  [7:0]  gen_ctrl_ff;     // Enable, continuous, resolution, standby run
  reg  [7:0]  acc_ctrl_ff;     // Accumulation count
  reg  [7:0]  ref_ctrl_ff;     // Reference and prescaler
  reg  [7:0]  dly_ctrl_ff;     // Init delay and sample delay
  reg  [7:0]  win_ctrl_ff;     // Window mode select
  reg  [7:0]  samp_ctrl_ff;    // Sample length
  reg  [7:0]  chan_sel_ff;     // Input channel
  reg         start_conv_ff;   // Start conversion bit
  reg         evt_start_en_ff; // Event start enable
  reg  [1:0]  int_en_ff;       // Interrupt enables
  reg  [1:0]  flags_ff;        // Interrupt flag bits
  reg         dbg_run_ff;      // Debug run bit
  reg  [7:0]  scratch_ff;      // Scratch byte
  reg  [15:0] result_ff;       // Conversion result
  reg  [15:0] low_thr_ff;      // Low threshold
  reg  [15:0] high_thr_ff;     // High threshold
  reg  [7:0]  trim_ff;         // Duty cycle trim
  // Conversion engine state
  reg  [1:0]  state_ff;        // Engine state
  reg  [8:0]  cnt_ff;          // Converter clock counter
  reg  [6:0]  acc_num_ff;      // Samples taken so far
  reg  [15:0] acc_ff;          // Running sum
  reg         need_init_ff;    // Init delay pending
  // Event trigger synchroniser and edge detect
  reg         evt_s1_ff;       // First stage, read only by second
  reg         evt_s2_ff;       // Second stage
  reg         evt_prev_ff;     // Previous synchronised level
  // Next values
  reg  [1:0]  nxt_state;
  reg  [8:0]  nxt_cnt;
  reg  [6:0]  nxt_acc_num;
  reg  [15:0] nxt_acc;
  reg         conv_done;       // Final result this cycle
  reg         win_hit;         // Window condition met
  reg  [15:0] final_sum;       // Completed accumulated value
  reg  [31:0] rd_data;         // Read mux value
  reg         rd_err;          // Unmapped address
  wire        tick;            // Converter clock enable
  wire        enabled;
  wire        run_ok;          // Converter may advance
  wire        evt_rise;
  wire        access;          // Completing APB access
  wire        wr;
  wire [4:0]  idx;
  wire        aligned;
  wire [15:0] sample_val;      // Sample after resolution select
  wire [6:0]  acc_target;      // Samples per conversion
  wire [8:0]  conv_len;        // Converter clocks per sample
  wire [8:0]  init_len;        // Init delay length
  wire [2:0]  win_mode;
  // Converter clock tick from the prescaler
  awsc_prescaler #(.CNT_W(8)) u_presc (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
    .div_code(ref_ctrl_ff[2:0]), .tick_ff(tick));
  assign enabled  = gen_ctrl_ff[`AWSC_B_ENABLE];
  // Halted by power-down, or by standby without run enable
  assign run_ok   = enabled & ~power_down_sleep &
                    ~(standby_sleep & ~gen_ctrl_ff[`AWSC_B_STBY_RUN]);
  assign evt_rise = evt_s2_ff & ~evt_prev_ff;
  assign access   = psel & penable & pready_ff;
  assign wr       = access & pwrite & aligned;
  assign idx      = paddr[6:2];
  assign aligned  = (paddr[1:0] == 2'b00);
  assign win_mode = win_ctrl_ff[2:0];
  // Eight-bit resolution drops the two low bits
  assign sample_val = gen_ctrl_ff[`AWSC_B_RES8] ?
                      {8'h00, sample_data[DATA_W-1:DATA_W-8]} :
                      {{(16-DATA_W){1'b0}}, sample_data};
  // Power of two sample count, reserved code means one
  assign acc_target = (acc_ctrl_ff[2:0] == `AWSC_ACC_RSVD) ? 7'h01 :
                      (7'h01 << acc_ctrl_ff[2:0]);
  assign conv_len = `AWSC_CONV_BASE + {4'h0, samp_ctrl_ff[4:0]} +
                    {5'h00, dly_ctrl_ff[3:0]};
  // Code 0 no delay, codes 1..5 give 16..256, reserved as none
  assign init_len = (dly_ctrl_ff[7:5] == `AWSC_DLY_NONE ||
                     dly_ctrl_ff[7:5] > `AWSC_DLY_MAX) ? 9'h000 :
                    (`AWSC_DLY_BASE << dly_ctrl_ff[7:5]);
  // Synchronise external trigger
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      evt_s1_ff   <= 1'b0;
      evt_s2_ff   <= 1'b0;
      evt_prev_ff <= 1'b0;
    end else if (ce) begin
      evt_s1_ff   <= event_trigger;
      evt_s2_ff   <= evt_s1_ff;
      evt_prev_ff <= evt_s2_ff;
    end
  end
  // Window comparator on the final sum
  always @* begin
    final_sum = acc_ff + sample_val;
    case (win_mode)
      `AWSC_WM_BELOW:   win_hit = (final_sum < low_thr_ff);
      `AWSC_WM_ABOVE:   win_hit = (final_sum > high_thr_ff);
      `AWSC_WM_INSIDE:  win_hit = (final_sum > low_thr_ff) &&
                                  (final_sum < high_thr_ff);
      `AWSC_WM_OUTSIDE: win_hit = (final_sum < low_thr_ff) ||
                                  (final_sum > high_thr_ff);
      default:          win_hit = 1'b0;
    endcase
  end
  // Conversion engine next state
  always @* begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_acc_num = acc_num_ff;
    nxt_acc     = acc_ff;
    conv_done   = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        // Start only on a converter clock edge
        if (start_conv_ff && run_ok && tick) begin
          nxt_cnt     = 9'h001;
          nxt_acc_num = 7'h00;
          nxt_acc     = 16'h0000;
          nxt_state = (need_init_ff && init_len != 9'h000) ? ST_INIT : ST_CONV;
        end
      end
      ST_INIT: begin
        // Paused while halted
        if (run_ok && tick) begin
          if (cnt_ff >= init_len) begin
            nxt_state = ST_CONV;
            nxt_cnt   = 9'h001;
          end else begin
            nxt_cnt = cnt_ff + 9'h001;
          end
        end
      end
      ST_CONV: begin
        // Halted conversion resumes where it stopped
        if (run_ok && tick) begin
          if (cnt_ff >= conv_len) begin
            nxt_cnt = 9'h001;
            if (acc_num_ff + 7'h01 >= acc_target) begin
              conv_done = 1'b1;
              nxt_state = ST_IDLE;
              if (gen_ctrl_ff[`AWSC_B_CONTINUOUS]) begin
                nxt_state   = ST_CONV;
                nxt_acc_num = 7'h00;
                nxt_acc     = 16'h0000;
              end
            end else begin
              nxt_acc_num = acc_num_ff + 7'h01;
              nxt_acc     = final_sum;
            end
          end else begin
            nxt_cnt = cnt_ff + 9'h001;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end
  // Engine registers; disable aborts the conversion
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state_ff     <= ST_IDLE;
      cnt_ff       <= 9'h000;
      acc_num_ff   <= 7'h00;
      acc_ff       <= `AWSC_RST16;
      need_init_ff <= 1'b1;
    end else if (ce) begin
      if (!enabled) begin
        state_ff     <= ST_IDLE;
        need_init_ff <= 1'b1;
      end else begin
        state_ff   <= nxt_state;
        cnt_ff     <= nxt_cnt;
        acc_num_ff <= nxt_acc_num;
        acc_ff     <= nxt_acc;
        if (state_ff == ST_INIT && nxt_state == ST_CONV) begin
          need_init_ff <= 1'b0;
        end
        // Standby seen while idle repeats the init delay on the next start
        if (standby_sleep && state_ff == ST_IDLE) begin
          need_init_ff <= 1'b1;
        end
      end
    end
  end
  // Read mux
  always @* begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    case (idx)
      `AWSC_IDX_GEN_CTRL:  rd_data[7:0]  = gen_ctrl_ff;
      `AWSC_IDX_ACC_CTRL:  rd_data[7:0]  = acc_ctrl_ff;
      `AWSC_IDX_REF_CTRL:  rd_data[7:0]  = ref_ctrl_ff;
      `AWSC_IDX_DLY_CTRL:  rd_data[7:0]  = dly_ctrl_ff;
      `AWSC_IDX_WIN_CTRL:  rd_data[7:0]  = win_ctrl_ff;
      `AWSC_IDX_SAMP_CTRL: rd_data[7:0]  = samp_ctrl_ff;
      `AWSC_IDX_CHAN_SEL:  rd_data[7:0]  = chan_sel_ff;
      `AWSC_IDX_CMD:       rd_data[0]    = start_conv_ff;
      `AWSC_IDX_EVT_CTRL:  rd_data[0]    = evt_start_en_ff;
      `AWSC_IDX_INT_EN:    rd_data[1:0]  = int_en_ff;
      `AWSC_IDX_INT_FLAG:  rd_data[1:0]  = flags_ff;
      `AWSC_IDX_DBG_CTRL:  rd_data[0]    = dbg_run_ff;
      `AWSC_IDX_SCRATCH:   rd_data[7:0]  = scratch_ff;
      `AWSC_IDX_RESULT:    rd_data[15:0] = result_ff;
      `AWSC_IDX_LOW_THR:   rd_data[15:0] = low_thr_ff;
      `AWSC_IDX_HIGH_THR:  rd_data[15:0] = high_thr_ff;
      `AWSC_IDX_TRIM:      rd_data[7:0]  = trim_ff;
      default:             rd_err        = 1'b1;
    endcase
    if (!aligned) begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b1;
    end
  end
  // APB slave: one wait state, write lands when pready is sampled
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else if (ce) begin
      if (access) begin
        pready_ff  <= 1'b0;
        pslverr_ff <= 1'b0;
        prdata_ff  <= 32'h0000_0000;
      end else if (psel && penable) begin
        pready_ff  <= 1'b1;
        pslverr_ff <= rd_err;
        prdata_ff  <= pwrite ? 32'h0000_0000 : rd_data;
      end
    end
  end
  // Software register writes
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      gen_ctrl_ff     <= `AWSC_RST8;
      acc_ctrl_ff     <= `AWSC_RST8;
      ref_ctrl_ff     <= `AWSC_RST8;
      dly_ctrl_ff     <= `AWSC_RST8;
      win_ctrl_ff     <= `AWSC_RST8;
      samp_ctrl_ff    <= `AWSC_RST8;
      chan_sel_ff     <= `AWSC_RST8;
      evt_start_en_ff <= 1'b0;
      int_en_ff       <= 2'b00;
      dbg_run_ff      <= 1'b0;
      scratch_ff      <= `AWSC_RST8;
      low_thr_ff      <= `AWSC_RST16;
      high_thr_ff     <= `AWSC_RST16;
      trim_ff         <= `AWSC_RST8;
    end else if (ce && wr) begin
      case (idx)
        `AWSC_IDX_GEN_CTRL:  gen_ctrl_ff  <= pwdata[7:0] & `AWSC_MSK_GEN_CTRL;
        `AWSC_IDX_ACC_CTRL:  acc_ctrl_ff  <= pwdata[7:0] & `AWSC_MSK_ACC_CTRL;
        `AWSC_IDX_REF_CTRL:  ref_ctrl_ff  <= pwdata[7:0] & `AWSC_MSK_REF_CTRL;
        `AWSC_IDX_DLY_CTRL:  dly_ctrl_ff  <= pwdata[7:0];
        `AWSC_IDX_WIN_CTRL:  win_ctrl_ff  <= pwdata[7:0] & `AWSC_MSK_WIN_CTRL;
        `AWSC_IDX_SAMP_CTRL: samp_ctrl_ff <= pwdata[7:0] & `AWSC_MSK_SAMP_CTRL;
        `AWSC_IDX_CHAN_SEL:  chan_sel_ff  <= pwdata[7:0] & `AWSC_MSK_CHAN_SEL;
        `AWSC_IDX_EVT_CTRL:  evt_start_en_ff <= pwdata[0];
        `AWSC_IDX_INT_EN:    int_en_ff    <= pwdata[1:0];
        `AWSC_IDX_DBG_CTRL:  dbg_run_ff   <= pwdata[0];
        `AWSC_IDX_SCRATCH:   scratch_ff   <= pwdata[7:0];
        `AWSC_IDX_LOW_THR:   low_thr_ff   <= pwdata[15:0];
        `AWSC_IDX_HIGH_THR:  high_thr_ff  <= pwdata[15:0];
        `AWSC_IDX_TRIM:      trim_ff      <= pwdata[7:0] & `AWSC_MSK_BIT0;
        default: ;
      endcase
    end
  end
  // Start bit: software or event edge sets, completion clears unless continuous
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      start_conv_ff <= 1'b0;
    end else if (ce) begin
      if (wr && idx == `AWSC_IDX_CMD && pwdata[0]) begin
        start_conv_ff <= 1'b1;
      end else if (evt_start_en_ff && evt_rise && enabled) begin
        start_conv_ff <= 1'b1;
      end else if (!enabled) begin
        start_conv_ff <= 1'b0;
      end else if (conv_done && !gen_ctrl_ff[`AWSC_B_CONTINUOUS]) begin
        start_conv_ff <= 1'b0;
      end else if (wr && idx == `AWSC_IDX_CMD && state_ff == ST_IDLE) begin
        start_conv_ff <= 1'b0;
      end
    end
  end
  // Result, flags, event pulse, interrupt and clock request
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      result_ff       <= `AWSC_RST16;
      flags_ff        <= 2'b00;
      result_event_ff <= 1'b0;
      irq_ff          <= 1'b0;
      clk_request_ff  <= 1'b0;
    end else if (ce) begin
      if (conv_done) result_ff <= final_sum;
      // Hardware set wins over software clear
      flags_ff[`AWSC_B_RDY] <= conv_done |
        (flags_ff[`AWSC_B_RDY] &
         ~(wr && idx == `AWSC_IDX_INT_FLAG && pwdata[`AWSC_B_RDY]));
      flags_ff[`AWSC_B_WIN] <= (conv_done & win_hit) |
        (flags_ff[`AWSC_B_WIN] &
         ~(wr && idx == `AWSC_IDX_INT_FLAG && pwdata[`AWSC_B_WIN]));
      result_event_ff <= conv_done & enabled;
      irq_ff <= |(flags_ff & int_en_ff);
      // Standby asks for the clock only while work is pending
      if (standby_sleep) begin
        clk_request_ff <= enabled & (start_conv_ff | (state_ff != ST_IDLE));
      end else begin
        clk_request_ff <= enabled;
      end
    end
  end
endmodule // awsc_top
`default_nettype wire

// ===== sim/awsc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: event router trigger line and analog sample source
module awsc_far_model #(
  parameter int DATA_W = 10
) (
  input  wire logic              clk_sys,
  input  wire logic              fire,
  input  wire logic [DATA_W-1:0] level,
  output logic                   event_trigger,
  output logic [DATA_W-1:0]      sample_data
);
  logic [2:0] hold_ff = 3'h0;  // Trigger high time left

  // Each request gives one clean rising edge, held four clocks
  always @(posedge clk_sys) begin
    if (fire) begin
      hold_ff <= 3'h4;
    end else if (hold_ff != 3'h0) begin
      hold_ff <= hold_ff - 3'h1;
    end
  end

  assign event_trigger = (hold_ff != 3'h0);
  // Analog level as converted by the sampling core
  assign sample_data   = level;
endmodule // awsc_far_model
`default_nettype wire

// ===== sim/awsc_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the converter control block
module awsc_top_assertions #(
  parameter int ADDR_W = 7
) (
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata_ff,
  input wire logic              pready_ff,
  input wire logic              pslverr_ff,
  input wire logic              power_down_sleep,
  input wire logic              result_event_ff,
  input wire logic              irq_ff,
  input wire logic              clk_request_ff
);
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // Setup cycle of a transfer
  sequence setup_s;
    psel && !penable;
  endsequence
  // Access cycle still waiting for the answer
  sequence wait_s;
    psel && penable && !pready_ff;
  endsequence

  bus_latency_a: assert property (setup_s ##1 wait_s |=> pready_ff)
    else $error("access phase not two cycles");
  ready_pulse_a: assert property (pready_ff |=> !pready_ff)
    else $error("ready held longer than one cycle");
  ready_framed_a: assert property (pready_ff |-> psel && penable)
    else $error("ready outside an access phase");
  unmapped_err_a: assert property (wait_s ##0 (paddr[6:2] == 5'h07)
    |=> pslverr_ff && prdata_ff == 32'h0)
    else $error("unmapped access not refused");
  err_framed_a: assert property (pslverr_ff |-> pready_ff)
    else $error("error without ready");
  event_pulse_a: assert property (result_event_ff |=> !result_event_ff)
    else $error("result event longer than one cycle");
  pwrdn_quiet_a: assert property (power_down_sleep [*4] |-> !result_event_ff)
    else $error("result event during power-down");
  irq_rise_a: assert property ($rose(irq_ff)
    |-> $past(result_event_ff) || $past(pready_ff && pwrite, 2))
    else $error("interrupt rose without flag or enable write");
  irq_fall_a: assert property ($fell(irq_ff) |-> $past(pready_ff && pwrite, 2))
    else $error("interrupt dropped without a clearing write");
  reset_quiet_a: assert property ($fell(sys_rst)
    |-> !(irq_ff || result_event_ff || clk_request_ff || pready_ff))
    else $error("outputs active right after reset");
endmodule // awsc_top_assertions

bind awsc_top awsc_top_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
  .pslverr_ff(pslverr_ff), .power_down_sleep(power_down_sleep),
  .result_event_ff(result_event_ff), .irq_ff(irq_ff), .clk_request_ff(clk_request_ff));
`default_nettype wire

// ===== sim/adc_window_event_sleep_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "awsc_defs.vh"
module adc_window_event_sleep_control_bench;
  localparam logic [15:0] LOW  = 16'h0100;  // Window low threshold
  localparam logic [15:0] HIGH = 16'h0200;  // Window high threshold
  logic        clk_sys = 1'b0;   // System clock
  logic        sys_rst = 1'b1;   // Sync reset
  logic        psel    = 1'b0;   // Bus select
  logic        penable = 1'b0;   // Bus enable
  logic        pwrite  = 1'b0;   // Bus direction
  logic [6:0]  paddr   = 7'h00;  // Bus byte address
  logic [31:0] pwdata  = 32'h0;  // Bus write data
  logic [31:0] prdata_ff;        // Read data
  logic        pready_ff;        // Ready
  logic        pslverr_ff;       // Error
  logic        stby    = 1'b0;   // Standby sleep
  logic        pdown   = 1'b0;   // Power-down sleep
  logic        fire    = 1'b0;   // Trigger request
  logic [9:0]  level   = 10'h0;  // Analog level
  logic        evt_trig;         // Event trigger
  logic [9:0]  samp;             // Sample bus
  logic        res_evt;          // Result event
  logic        irq;              // Interrupt
  logic        clk_req;          // Clock request
  int          num_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;          // Cycle count
  int          evt_cnt = 0;      // Result events seen
  int          lat = 0;          // Last wait length

  awsc_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .event_trigger(evt_trig), .sample_data(samp), .standby_sleep(stby),
    .power_down_sleep(pdown), .result_event_ff(res_evt), .irq_ff(irq),
    .clk_request_ff(clk_req));
  awsc_far_model far (.clk_sys(clk_sys), .fire(fire), .level(level),
    .event_trigger(evt_trig), .sample_data(samp));

  // Clock
  always #2 clk_sys = ~clk_sys;

  // Event counter and hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (res_evt === 1'b1) evt_cnt <= evt_cnt + 1;
    if (cyc == 40000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [4:0] i, input logic [31:0] d,
                     output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    while (pready_ff !== 1'b1) @(posedge clk_sys);
    q = prdata_ff;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [4:0] i, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, i, d, q);
  endtask

  task automatic rdc(input logic [4:0] i, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, i, 32'h0, q);
    chk(q, e);
  endtask

  // Wait for the next result event, bounded
  task automatic wait_done(input int lim);
    int c0;
    c0 = evt_cnt;
    lat = 0;
    while (evt_cnt == c0 && lat < lim) begin
      @(posedge clk_sys);
      lat++;
    end
    chk(32'(lat < lim), 32'h1);
    if (lat >= lim) end_sim();
  endtask

  task automatic fire_evt();
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
  endtask

  // Expected window match for a mode code
  function automatic logic win_hit(input logic [2:0] m, input logic [15:0] v);
    case (m)
      `AWSC_WM_BELOW:   return v < LOW;
      `AWSC_WM_ABOVE:   return v > HIGH;
      `AWSC_WM_INSIDE:  return v > LOW && v < HIGH;
      `AWSC_WM_OUTSIDE: return v < LOW || v > HIGH;
      default:          return 1'b0;
    endcase
  endfunction

  task automatic t_regs();
    rdc(`AWSC_IDX_GEN_CTRL, 32'h0);
    wr(`AWSC_IDX_LOW_THR, 32'hfffe_beef);
    rdc(`AWSC_IDX_LOW_THR, 32'hbeef);
    wr(`AWSC_IDX_HIGH_THR, 32'h1234);
    rdc(`AWSC_IDX_HIGH_THR, 32'h1234);
    wr(`AWSC_IDX_WIN_CTRL, 32'hff);
    rdc(`AWSC_IDX_WIN_CTRL, 32'h7);
    wr(`AWSC_IDX_EVT_CTRL, 32'hff);
    rdc(`AWSC_IDX_EVT_CTRL, 32'h1);
    wr(`AWSC_IDX_RESULT, 32'hffff);
    rdc(`AWSC_IDX_RESULT, 32'h0);
    rdc(5'h07, 32'h0);
    wr(`AWSC_IDX_EVT_CTRL, 32'h0);
    wr(`AWSC_IDX_WIN_CTRL, 32'h0);
  endtask

  task automatic t_single();
    wr(`AWSC_IDX_GEN_CTRL, 32'h1);
    wr(`AWSC_IDX_INT_EN, 32'h1);
    level <= 10'h2a5;
    wr(`AWSC_IDX_CMD, 32'h1);
    rdc(`AWSC_IDX_CMD, 32'h1);
    wait_done(300);
    chk(32'(lat > 10 && lat < 30), 32'h1);
    rdc(`AWSC_IDX_RESULT, 32'h02a5);
    rdc(`AWSC_IDX_CMD, 32'h0);
    rdc(`AWSC_IDX_INT_FLAG, 32'h1);
    chk(32'(irq), 32'h1);
    wr(`AWSC_IDX_INT_FLAG, 32'h1);
    rdc(`AWSC_IDX_INT_FLAG, 32'h0);
    chk(32'(irq), 32'h0);
  endtask

  task automatic t_window();
    wr(`AWSC_IDX_LOW_THR, 32'(LOW));
    wr(`AWSC_IDX_HIGH_THR, 32'(HIGH));
    wr(`AWSC_IDX_INT_EN, 32'h3);
    for (int m = 0; m < 5; m++) begin
      wr(`AWSC_IDX_WIN_CTRL, 32'(m));
      for (int i = 1; i < 6; i++) begin
        level <= 10'(i * 128);
        wr(`AWSC_IDX_CMD, 32'h1);
        wait_done(300);
        rdc(`AWSC_IDX_INT_FLAG, {30'h0, win_hit(3'(m), 16'(i * 128)), 1'b1});
        wr(`AWSC_IDX_INT_FLAG, 32'h3);
      end
    end
  endtask

  task automatic t_accum();
    int c0;
    wr(`AWSC_IDX_ACC_CTRL, 32'h2);
    wr(`AWSC_IDX_WIN_CTRL, 32'(`AWSC_WM_OUTSIDE));
    c0 = evt_cnt;
    level <= 10'h050;
    wr(`AWSC_IDX_CMD, 32'h1);
    repeat (400) @(posedge clk_sys);
    chk(32'(evt_cnt - c0), 32'h1);
    rdc(`AWSC_IDX_RESULT, 32'h0140);
    rdc(`AWSC_IDX_INT_FLAG, 32'h1);
    wr(`AWSC_IDX_INT_FLAG, 32'h3);
    wr(`AWSC_IDX_ACC_CTRL, 32'h0);
    wr(`AWSC_IDX_WIN_CTRL, 32'h0);
  endtask

  task automatic t_event();
    wr(`AWSC_IDX_EVT_CTRL, 32'h1);
    level <= 10'h3ff;
    fire_evt();
    repeat (8) @(posedge clk_sys);
    rdc(`AWSC_IDX_CMD, 32'h1);
    wait_done(300);
    rdc(`AWSC_IDX_RESULT, 32'h03ff);
    rdc(`AWSC_IDX_CMD, 32'h0);
    wr(`AWSC_IDX_INT_FLAG, 32'h3);
  endtask

  task automatic t_cont();
    wr(`AWSC_IDX_GEN_CTRL, 32'h3);
    wr(`AWSC_IDX_CMD, 32'h1);
    wait_done(300);
    wait_done(300);
    chk(32'(lat < 34), 32'h1);
    rdc(`AWSC_IDX_CMD, 32'h1);
    wr(`AWSC_IDX_GEN_CTRL, 32'h0);
    wr(`AWSC_IDX_GEN_CTRL, 32'h1);
    wr(`AWSC_IDX_INT_FLAG, 32'h3);
  endtask

  task automatic t_pwrdn();
    int c0;
    wr(`AWSC_IDX_CMD, 32'h1);
    repeat (4) @(posedge clk_sys);
    pdown <= 1'b1;
    c0 = evt_cnt;
    repeat (200) @(posedge clk_sys);
    chk(32'(evt_cnt - c0), 32'h0);
    pdown <= 1'b0;
    wait_done(300);
    rdc(`AWSC_IDX_INT_FLAG, 32'h1);
    wr(`AWSC_IDX_INT_FLAG, 32'h3);
  endtask

  task automatic t_stby();
    int c0;
    wr(`AWSC_IDX_DLY_CTRL, 32'h20);
    wr(`AWSC_IDX_GEN_CTRL, 32'h81);
    stby <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(32'(clk_req), 32'h0);
    fire_evt();
    repeat (10) @(posedge clk_sys);
    chk(32'(clk_req), 32'h1);
    wait_done(300);
    chk(32'(lat > 40), 32'h1);
    repeat (4) @(posedge clk_sys);
    chk(32'(clk_req), 32'h0);
    wr(`AWSC_IDX_GEN_CTRL, 32'h1);
    c0 = evt_cnt;
    fire_evt();
    repeat (300) @(posedge clk_sys);
    chk(32'(evt_cnt - c0), 32'h0);
    stby <= 1'b0;
    wr(`AWSC_IDX_GEN_CTRL, 32'h0);
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_single();
    t_window();
    t_accum();
    t_event();
    t_cont();
    t_pwrdn();
    t_stby();
    end_sim();
  end
endmodule // adc_window_event_sleep_control_bench
`default_nettype wire
